// ===== logic/adcsfs_pkg.sv
// shared constants and types of the converter serial frame port
package adcsfs_pkg;
    // frame layout: one status word followed by the channel words
    localparam int WORD_BITS     = 24;
    localparam int CHANNELS      = 4;
    localparam int FRAME_WORDS   = CHANNELS + 1;
    localparam int FRAME_BITS    = FRAME_WORDS * WORD_BITS;
    localparam int BIT_CNT_W     = 7;
    localparam logic [BIT_CNT_W-1:0] FRAME_BITS_C = BIT_CNT_W'(FRAME_BITS);
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST  = 7'h00;
    // status word fields
    localparam int STATUS_REALIGN_BIT = 14;
    localparam int STATUS_STALE_BIT   = 13;
    // master clock periods per conversion period
    localparam int PERIOD_CNT_W  = 10;
    localparam int MCLK_PER_CONV = 1024;
    localparam logic [PERIOD_CNT_W-1:0] PERIOD_LAST =
        PERIOD_CNT_W'(MCLK_PER_CONV - 1);
    localparam logic [PERIOD_CNT_W-1:0] PERIOD_ZERO = 10'h000;
    // result buffer depth
    localparam int BUF_DEPTH     = 2;

    typedef logic [WORD_BITS-1:0] adcsfs_word_t;

    // one conversion result as it travels to the shift register
    typedef struct packed {
        adcsfs_word_t                status;
        adcsfs_word_t [CHANNELS-1:0] ch;
    } adcsfs_frame_t;

    localparam adcsfs_frame_t FRAME_RST = '0;
endpackage

// ===== logic/adcsfs_buf2.sv
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module adcsfs_buf2 (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    // filling side
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire adcsfs_pkg::adcsfs_frame_t in_data,
    // draining side
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output adcsfs_pkg::adcsfs_frame_t   out_data
);
    import adcsfs_pkg::*;

    adcsfs_frame_t mem_reg [BUF_DEPTH];  // entry storage
    adcsfs_frame_t mem_next [BUF_DEPTH];
    logic          wr_ptr_reg, wr_ptr_next;  // next free entry
    logic          rd_ptr_reg, rd_ptr_next;  // oldest entry
    logic [1:0]    count_reg, count_next;    // entries held
    logic          push, pop;

    // honest full and empty from the occupancy count
    assign in_ready  = (count_reg != 2'(BUF_DEPTH));
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];

    // next pointers, count and storage
    always_comb begin
        push        = in_valid & in_ready;
        pop         = out_ready & out_valid;
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next          = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        // count moves only when one side acts alone
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    // register the buffer state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_reg[0] <= FRAME_RST;
            mem_reg[1] <= FRAME_RST;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else if (ce) begin
            mem_reg    <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end
endmodule // adcsfs_buf2

// ===== logic/adcsfs_port.sv
// serial frame port: result buffer, frame shifter, alignment check
//
// Summary of operation
// - serial output released whenever select is high
// - two-deep buffer; overflow drops oldest, no ready signalled
// - result consumed only after full frame
// - misaligned strobe sets realign flag again
// - alignment strobe checks, never starts conversion
// - aligned devices convert together, same tick
`timescale 1ns/1ps
module adcsfs_port (
    // clock, reset, enable
    input  wire logic                      CLOCK,
    input  wire logic                      RST_N,
    input  wire logic                      CE,
    // pins from the host
    input  wire logic                      CS_N,
    input  wire logic                      SCLK,
    input  wire logic                      SYNC_N,
    input  wire logic                      MASTER_CLOCK_IN,
    // serial output pin
    output logic                           DOUT_O,
    output logic                           DOUT_OE,
    output logic                           CONVERSION_READY_N,
    // results from the converter core
    input  wire logic                      CONV_VALID,
    input  wire adcsfs_pkg::adcsfs_frame_t CONV_DATA,
    output logic                           CONV_READY,
    output logic                           SAMPLE_TICK,
    output logic                           REALIGN_EVENT_FLAG
);
    import adcsfs_pkg::*;

    typedef enum logic {LINK_IDLE, LINK_SHIFT} adcsfs_link_t;

    // two-flop synchronisers plus one edge stage
    logic [2:0] cs_pipe_reg;     // select pipeline
    logic [2:0] sclk_pipe_reg;   // shift clock pipeline
    logic [2:0] sync_pipe_reg;   // alignment strobe pipeline
    logic [2:0] mclk_pipe_reg;   // master clock pipeline
    logic       cs_fall, cs_high, sclk_rise, sclk_fall;
    logic       sync_fall, mclk_rise;

    // link state
    adcsfs_link_t          link_reg, link_next;
    adcsfs_frame_t         shift_reg, shift_next;     // outgoing frame
    logic [BIT_CNT_W-1:0]  bit_cnt_reg, bit_cnt_next; // bits sampled
    logic                  dout_reg, dout_next;
    logic                  oe_reg, oe_next;
    logic                  done_reg, done_next;       // frame consumed
    logic                  conversion_ready_n_n_reg, conversion_ready_n_n_next;

    // conversion period and alignment state
    logic [PERIOD_CNT_W-1:0] period_reg, period_next;
    logic                    tick_reg, tick_next;
    logic                    flag_reg, flag_next;

    // buffer feed state
    adcsfs_frame_t pend_data_reg, pend_data_next;  // result waiting
    logic          pend_valid_reg, pend_valid_next;
    logic          pend_drop_reg, pend_drop_next;  // oldest was dropped
    logic          conv_ready_reg, conv_ready_next;

    // buffer wires
    logic          buf_in_ready, buf_out_valid, buf_pop, drop_now;
    logic          push_now;
    adcsfs_frame_t buf_out_data;

    // synchronise every pin before any logic reads it
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cs_pipe_reg   <= 3'h7;
            sclk_pipe_reg <= 3'h0;
            sync_pipe_reg <= 3'h7;
            mclk_pipe_reg <= 3'h0;
        end else if (CE) begin
            cs_pipe_reg   <= {cs_pipe_reg[1:0], CS_N};
            sclk_pipe_reg <= {sclk_pipe_reg[1:0], SCLK};
            sync_pipe_reg <= {sync_pipe_reg[1:0], SYNC_N};
            mclk_pipe_reg <= {mclk_pipe_reg[1:0], MASTER_CLOCK_IN};
        end
    end

    // edges seen between the second and third stages only
    assign cs_high   = cs_pipe_reg[1];
    assign cs_fall   = !cs_pipe_reg[1] && cs_pipe_reg[2];
    assign sclk_rise = sclk_pipe_reg[1] && !sclk_pipe_reg[2];
    assign sclk_fall = !sclk_pipe_reg[1] && sclk_pipe_reg[2];
    assign sync_fall = !sync_pipe_reg[1] && sync_pipe_reg[2];
    assign mclk_rise = mclk_pipe_reg[1] && !mclk_pipe_reg[2];

    // result buffer between the core and the shifter
    adcsfs_buf2 u_buf (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .ce        (CE),
        .in_valid  (push_now),
        .in_ready  (buf_in_ready),
        .in_data   (pend_data_reg),
        .out_valid (buf_out_valid),
        .out_ready (buf_pop),
        .out_data  (buf_out_data)
    );

    // feed: push a pending result, or drop the oldest when full
    assign push_now = pend_valid_reg && buf_in_ready;
    assign drop_now = pend_valid_reg && !buf_in_ready && !done_reg;
    assign buf_pop  = done_reg || drop_now;

    // next values of the buffer feed
    always_comb begin
        pend_data_next  = pend_data_reg;
        pend_valid_next = pend_valid_reg;
        pend_drop_next  = pend_drop_reg;
        if (push_now) begin
            // slot moves into the buffer
            pend_valid_next = 1'b0;
            pend_drop_next  = 1'b0;
        end else if (drop_now) begin
            // overflow: this result will not raise ready
            pend_drop_next = 1'b1;
        end
        if (CONV_VALID && conv_ready_reg) begin
            // take a new result from the core
            pend_data_next  = CONV_DATA;
            pend_valid_next = 1'b1;
        end
        conv_ready_next = !pend_valid_next;
    end

    // register the buffer feed
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pend_data_reg  <= FRAME_RST;
            pend_valid_reg <= 1'b0;
            pend_drop_reg  <= 1'b0;
            conv_ready_reg <= 1'b0;
        end else if (CE) begin
            pend_data_reg  <= pend_data_next;
            pend_valid_reg <= pend_valid_next;
            pend_drop_reg  <= pend_drop_next;
            conv_ready_reg <= conv_ready_next;
        end
    end

    // next values of the frame shifter and ready output
    always_comb begin
        link_next    = link_reg;
        shift_next   = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        dout_next    = dout_reg;
        done_next    = 1'b0;
        conversion_ready_n_n_next  = conversion_ready_n_n_reg;
        oe_next      = !cs_high;
        if (push_now && !pend_drop_reg) begin
            // fresh result in the buffer: signal ready
            conversion_ready_n_n_next = 1'b0;
        end
        unique case (link_reg)
            LINK_IDLE: begin
                if (cs_fall) begin
                    // load the oldest result, or a stale frame
                    link_next    = LINK_SHIFT;
                    bit_cnt_next = BIT_CNT_RST;
                    // a result pushed in this very cycle still signals
                    conversion_ready_n_n_next  = !(push_now && !pend_drop_reg);
                    shift_next   = buf_out_valid ? buf_out_data
                                                 : FRAME_RST;
                    shift_next.status[STATUS_REALIGN_BIT] = flag_reg;
                    shift_next.status[STATUS_STALE_BIT] = !buf_out_valid;
                    dout_next = shift_next[FRAME_BITS-1];
                end
            end
            LINK_SHIFT: begin
                if (cs_high) begin
                    // frame aborted or ended; result kept if short
                    link_next = LINK_IDLE;
                end else if (sclk_fall &&
                             bit_cnt_reg != FRAME_BITS_C) begin
                    // host samples a bit; last one consumes result
                    bit_cnt_next = bit_cnt_reg + 7'h01;
                    done_next    = (bit_cnt_next == FRAME_BITS_C) &&
                                   buf_out_valid &&
                                   !shift_reg.status[STATUS_STALE_BIT];
                end else if (sclk_rise && bit_cnt_reg != BIT_CNT_RST) begin
                    // present the next bit
                    shift_next = shift_reg << 1;
                    dout_next  = shift_next[FRAME_BITS-1];
                end
            end
        endcase
    end

    // register the frame shifter
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            link_reg    <= LINK_IDLE;
            shift_reg   <= FRAME_RST;
            bit_cnt_reg <= BIT_CNT_RST;
            dout_reg    <= 1'b0;
            oe_reg      <= 1'b0;
            done_reg    <= 1'b0;
            conversion_ready_n_n_reg  <= 1'b1;
        end else if (CE) begin
            link_reg    <= link_next;
            shift_reg   <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            dout_reg    <= dout_next;
            oe_reg      <= oe_next;
            done_reg    <= done_next;
            conversion_ready_n_n_reg  <= conversion_ready_n_n_next;
        end
    end

    // next values of the period counter and realign flag
    always_comb begin
        period_next = period_reg;
        tick_next   = 1'b0;
        flag_next   = flag_reg;
        if (mclk_rise) begin
            // free-running period, never started by the strobe
            period_next = (period_reg == PERIOD_LAST) ? PERIOD_ZERO
                          : period_reg + 10'h001;
            tick_next   = (period_reg == PERIOD_LAST);
        end
        if (done_reg) begin
            // flag reported in a consumed frame is cleared
            flag_next = 1'b0;
        end
        if (sync_fall && period_reg != PERIOD_ZERO) begin
            // strobe off the boundary: realign, set wins over clear
            period_next = PERIOD_ZERO;
            flag_next   = 1'b1;
        end
    end

    // register the period counter and realign flag
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            period_reg <= PERIOD_ZERO;
            tick_reg   <= 1'b0;
            flag_reg   <= 1'b0;
        end else if (CE) begin
            period_reg <= period_next;
            tick_reg   <= tick_next;
            flag_reg   <= flag_next;
        end
    end

    // outputs straight from flip-flops
    assign DOUT_O             = dout_reg;
    assign DOUT_OE            = oe_reg;
    assign CONVERSION_READY_N = conversion_ready_n_n_reg;
    assign CONV_READY         = conv_ready_reg;
    assign SAMPLE_TICK        = tick_reg;
    assign REALIGN_EVENT_FLAG = flag_reg;
endmodule // adcsfs_port

// ===== verif/adcsfs_port_props.sv
// pin-level checks of the converter serial frame port
`timescale 1ns/1ps
module adcsfs_port_props (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // pins from the host and the core
    input wire logic CS_N,
    input wire logic SYNC_N,
    input wire logic CONV_VALID,
    // outputs of the port
    input wire logic DOUT_OE,
    input wire logic CONVERSION_READY_N,
    input wire logic CONV_READY,
    input wire logic SAMPLE_TICK,
    input wire logic REALIGN_EVENT_FLAG
);
    // a result taken from the core in this cycle
    logic take;
    assign take = CONV_VALID && CONV_READY;
    // all checks on the system clock, quiet in reset
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    AST_DOUT_RELEASED: assert property (CS_N [*5] |-> !DOUT_OE)
        else $error("serial output driven while deselected");
    AST_DOUT_DRIVEN: assert property (!CS_N [*6] |-> DOUT_OE)
        else $error("serial output not driven while selected");
    AST_TAKE_ONCE: assert property (take |=> !CONV_READY)
        else $error("core ready stayed high after a take");
    AST_READY_AFTER_PUSH: assert property
        ($fell(CONVERSION_READY_N) |-> $past(take, 2))
        else $error("data ready fell without a stored result");
    AST_READY_CLEARED: assert property
        ($rose(DOUT_OE) |-> CONVERSION_READY_N || $past(take, 2))
        else $error("data ready not cleared at frame start");
    AST_FLAG_CAUSE: assert property
        ($rose(REALIGN_EVENT_FLAG) |-> !$past(SYNC_N, 2))
        else $error("realign flag set without a strobe");
    AST_NO_START: assert property
        ($rose(REALIGN_EVENT_FLAG) |-> !SAMPLE_TICK [*8])
        else $error("strobe started a conversion");
    AST_FLAG_CLEAR: assert property
        ($fell(REALIGN_EVENT_FLAG) |-> DOUT_OE)
        else $error("realign flag cleared outside a frame");
endmodule // adcsfs_port_props

bind adcsfs_port adcsfs_port_props u_props (
    .CLOCK(CLOCK), .RST_N(RST_N), .CS_N(CS_N), .SYNC_N(SYNC_N),
    .CONV_VALID(CONV_VALID), .DOUT_OE(DOUT_OE), .CONV_READY(CONV_READY),
    .CONVERSION_READY_N(CONVERSION_READY_N), .SAMPLE_TICK(SAMPLE_TICK),
    .REALIGN_EVENT_FLAG(REALIGN_EVENT_FLAG));

// ===== verif/adcsfs_host.sv
// host serial controller model: selects the port, clocks frames out
`timescale 1ns/1ps
module adcsfs_host (
    // select and serial clock towards the port
    output logic      cs_n,
    output logic      sclk,
    // level seen on the shared data wire
    input  wire logic dout
);
    // idle: deselected, serial clock parked low between frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
    end
    // one frame of n clocks; the last bit ends up lowest
    task automatic read_frame(input int n, output logic [119:0] got);
        got = '0;
        #25 cs_n = 1'b0;
        #300;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            #100 sclk = 1'b0;
            // sample late in the low phase, long after the shift
            #100 got = {got[118:0], dout};
        end
        #100 cs_n = 1'b1;
        #300;
    endtask
endmodule // adcsfs_host

// ===== verif/test_adc_serial_frame_sync_port.sv
// self-checking bench of the converter serial frame port
`timescale 1ns/1ps
module test_adc_serial_frame_sync_port;
    import adcsfs_pkg::*;
    // design pins
    logic          clk, rst_n, sync_n, mclk, conv_valid, dout_o, dout_oe;
    logic          ready_n, conv_ready, tick, flag;
    wire logic     cs_n, sclk;
    adcsfs_frame_t conv_data;
    // reference model: stored results, realign flag, random source
    logic [119:0]  q[$];
    logic [31:0]   seed;
    logic          flg, dout_last;
    int            errors, compares;
    // released wire shows the inverse of the last driven bit
    wire logic     dout_w = dout_oe ? dout_o : ~dout_last;

    always #12.5 clk = ~clk;
    always #50 mclk = ~mclk;
    // remember the last driven data bit
    always @(posedge clk) if (dout_oe) dout_last <= dout_o;

    adcsfs_port u_dut (
        .CLOCK(clk), .RST_N(rst_n), .CE(1'b1), .CS_N(cs_n),
        .SCLK(sclk), .SYNC_N(sync_n), .MASTER_CLOCK_IN(mclk),
        .DOUT_O(dout_o), .DOUT_OE(dout_oe),
        .CONVERSION_READY_N(ready_n), .CONV_VALID(conv_valid),
        .CONV_DATA(conv_data), .CONV_READY(conv_ready),
        .SAMPLE_TICK(tick), .REALIGN_EVENT_FLAG(flag));
    adcsfs_host u_host (.cs_n(cs_n), .sclk(sclk), .dout(dout_w));

    // report and count a mismatch
    task automatic fail(input string m);
        $display("wrong value at %0t ns: %s", $time, m);
        errors++;
    endtask
    // single pin or flag comparison
    task automatic cmp_bit(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) fail(m);
    endtask
    // whole serial frame comparison
    task automatic cmp_frame(input logic [119:0] got, input logic [119:0] exp);
        compares++;
        if (got !== exp) fail("serial frame");
    endtask
    // verdict and end of run
    task automatic end_sim();
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // wait n edges, then step just past the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // shift register source of random frames
    function automatic logic [119:0] rnd_frame();
        logic [119:0] f;
        f = '0;
        repeat (4) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
            f = {f[87:0], seed};
        end
        return f;
    endfunction
    // offer one result to the port and mirror it in the model
    task automatic push(input logic [119:0] f);
        int n;
        n = 0;
        // raise valid only once ready stands, then hold it over the edge
        while (conv_ready !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        if (n >= 40) begin
            fail("core take timed out");
            end_sim();
        end
        conv_valid = 1'b1;
        conv_data  = f;
        step(1);
        conv_valid = 1'b0;
        cmp_bit(conv_ready, 1'b0, "core ready after take");
        if (q.size() == 2) void'(q.pop_front());
        q.push_back(f);
    endtask
    // read a frame of n clocks and compare with the model
    task automatic read(input int n);
        logic [119:0] got, exp;
        exp = (q.size() > 0) ? q[0] : 120'h0;
        exp[109] = (q.size() == 0);
        exp[110] = flg;
        u_host.read_frame(n, got);
        cmp_frame(got, exp >> (120 - n));
        if (n == 120 && q.size() > 0) begin
            void'(q.pop_front());
            flg = 1'b0;
        end
        step(1);
        cmp_bit(dout_oe, 1'b0, "output not released");
        cmp_bit(flag, flg, "realign flag");
    endtask
    // strobe alignment and count master clocks to the next tick
    task automatic tick_check();
        int   n, c;
        logic m;
        n = 0;
        c = 0;
        m = mclk;
        sync_n = 1'b0;
        while (tick !== 1'b1 && c < 5000) begin
            @(posedge clk);
            if (mclk && !m) n++;
            m = mclk;
            c++;
            #1 if (c == 8) sync_n = 1'b1;
        end
        if (c >= 5000) begin
            fail("no sample tick");
            end_sim();
        end
        cmp_bit(n >= MCLK_PER_CONV - 4 && n <= MCLK_PER_CONV + 4, 1'b1,
                "tick spacing");
        cmp_bit(flag, 1'b1, "realign flag not set");
        flg = 1'b1;
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        mclk = 1'b0;
        rst_n = 1'b0;
        sync_n = 1'b1;
        conv_valid = 1'b0;
        conv_data = FRAME_RST;
        dout_last = 1'b0;
        seed = 32'h2da1;
        flg = 1'b0;
        errors = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        step(2);
        cmp_bit(ready_n, 1'b1, "ready after reset");
        read(120);
        push(rnd_frame());
        step(3);
        cmp_bit(ready_n, 1'b0, "ready not low");
        read(48);
        read(120);
        cmp_bit(ready_n, 1'b1, "ready after read");
        // two unread results fill the buffer; a third drops the oldest
        repeat (2) push(rnd_frame());
        read(48);
        push(rnd_frame());
        step(3);
        cmp_bit(ready_n, 1'b1, "ready on overflow push");
        repeat (3) read(120);
        tick_check();
        push(rnd_frame());
        read(120);
        // strobe again once the flag was cleared
        sync_n = 1'b0;
        step(8);
        sync_n = 1'b1;
        step(4);
        cmp_bit(flag, 1'b1, "flag not set again");
        end_sim();
    end
endmodule // test_adc_serial_frame_sync_port
